//--- src/tpd_pkg.sv
// constants and types shared by the totem-pole drive sequencer
package tpd_pkg;
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned CLK_NS = 100;
  localparam int unsigned CHARGE_MAX_MS = 300;
  localparam int unsigned CHARGE_RESTART_MS = 450;
  localparam int unsigned AC_LOSS_DELAY_MS = 128;
  localparam int unsigned SOFT_START_MS = 80;
  localparam int unsigned MIN_ON_NS = 100;
  localparam int unsigned DEAD_NS = 200;
  localparam int unsigned LINE_HI_HZ = 72;
  localparam int unsigned LINE_LO_HZ = 41;
  localparam int unsigned VALID_EDGES = 4;
  localparam int unsigned BOOST_DETECT_PCT = 95;
  localparam int unsigned BOOST_RECOVER_PCT = 98;
  localparam int unsigned CHARGE_MAX_CYC = CHARGE_MAX_MS * (CLK_HZ / 1000);
  localparam int unsigned CHARGE_RESTART_CYC = CHARGE_RESTART_MS * (CLK_HZ / 1000);
  localparam int unsigned AC_LOSS_DELAY_CYC = AC_LOSS_DELAY_MS * (CLK_HZ / 1000);
  localparam int unsigned SOFT_START_CYC = SOFT_START_MS * (CLK_HZ / 1000);
  localparam int unsigned MIN_ON_CYC = (MIN_ON_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned DEAD_CYC = (DEAD_NS + CLK_NS - 1) / CLK_NS;
  // half-period bounds in cycles of one polarity interval
  localparam int unsigned HALF_MIN_CYC = CLK_HZ / (2 * LINE_HI_HZ);
  localparam int unsigned HALF_MAX_CYC = CLK_HZ / (2 * LINE_LO_HZ);
  localparam int unsigned DATA_W = 12;
  localparam int unsigned REF_W = 12;
  localparam logic [11:0] REF_FULL = 12'hFFF;
  typedef enum logic [2:0] {
    TPD_SUP_IDLE, TPD_SUP_START, TPD_SUP_RUN, TPD_SUP_RECHG, TPD_SUP_COOL, TPD_SUP_XWAIT,
    TPD_SUP_XDIS, TPD_SUP_OFF
  } tpd_sup_t;
endpackage

//--- src/tpd_line_mon.sv
// line polarity qualifier: four in-range polarity edges then a rising edge
`timescale 1ns/1ps
module tpd_line_mon #(
  parameter int unsigned HALF_MIN = tpd_pkg::HALF_MIN_CYC,
  parameter int unsigned HALF_MAX = tpd_pkg::HALF_MAX_CYC
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic pol_i,
  output logic line_ok_o,
  output logic pol_rise_o
);
  logic pol_q;
  logic pol_d;
  logic [20:0] per_q;
  logic [20:0] per_d;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic edge_w;
  logic inrange_w;

  assign edge_w = pol_i ^ pol_q;
  assign inrange_w = (per_q >= 21'(HALF_MIN)) && (per_q <= 21'(HALF_MAX));
  assign pol_rise_o = pol_i & ~pol_q;
  assign line_ok_o = (cnt_q >= 3'(tpd_pkg::VALID_EDGES));

  always_comb
  begin
    pol_d = pol_i;
    per_d = per_q;
    cnt_d = cnt_q;
    if (edge_w)
    begin
      per_d = 21'h000001;
      if (inrange_w)
      begin
        if (cnt_q < 3'(tpd_pkg::VALID_EDGES))
          cnt_d = cnt_q + 3'h1;
      end
      else
        cnt_d = 3'h0;
    end
    else if (per_q < 21'(HALF_MAX + 1))
      per_d = per_q + 21'h000001;
    else
      cnt_d = 3'h0;
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      pol_q <= 1'b0;
      per_q <= 21'h000000;
      cnt_q <= 3'h0;
    end
    else if (clk_en_i)
    begin
      pol_q <= pol_d;
      per_q <= per_d;
      cnt_q <= cnt_d;
    end
  end

  AST_EDGE_RESET: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    clk_en_i && edge_w && !inrange_w |=> cnt_q == 3'h0)
    else $error("out of range edge did not clear count");
endmodule

//--- src/tpd_top.sv
// totem-pole drive sequencer: supply start-up, discharge, start gating, on-time, legs
`timescale 1ns/1ps
module tpd_top #(
  parameter int unsigned CHARGE_MAX = tpd_pkg::CHARGE_MAX_CYC,
  parameter int unsigned CHARGE_RESTART = tpd_pkg::CHARGE_RESTART_CYC,
  parameter int unsigned AC_LOSS_DELAY = tpd_pkg::AC_LOSS_DELAY_CYC,
  parameter int unsigned SOFT_START = tpd_pkg::SOFT_START_CYC,
  parameter int unsigned HALF_MIN = tpd_pkg::HALF_MIN_CYC,
  parameter int unsigned HALF_MAX = tpd_pkg::HALF_MAX_CYC
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic hv_start_i,
  input wire logic above_boost_i,
  input wire logic above_release_i,
  input wire logic above_rechg_low_i,
  input wire logic above_rechg_high_i,
  input wire logic above_stop_i,
  input wire logic ac_loss_i,
  input wire logic brownout_ok_i,
  input wire logic polarity_i,
  input wire logic valley_i,
  input wire logic sync_load_i,
  input wire logic [11:0] comp_i,
  input wire logic [11:0] limit_i,
  input wire logic [11:0] fb_i,
  output logic fast_low_drive_o,
  output logic fast_high_drive_o,
  output logic slow_low_drive_o,
  output logic slow_high_drive_o,
  output logic charger_en_o,
  output logic charge_boost_o,
  output logic xcap_drain_o,
  output logic switching_o,
  output logic [11:0] vref_o,
  output logic undershoot_gain_boost_o,
  output logic halted_o
);
  // two-flop synchronisers for all single-bit comparator and pin inputs; comp_i, limit_i and fb_i are used unsynchronised
  localparam int unsigned NS = 14;
  logic [NS-1:0] s1_q;
  logic [NS-1:0] s2_q;
  logic [NS-1:0] raw_w;
  assign raw_w = {hv_start_i, above_boost_i, above_release_i, above_rechg_low_i,
                  above_rechg_high_i, above_stop_i, ac_loss_i, brownout_ok_i,
                  polarity_i, valley_i, sync_load_i, 3'h0};
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      s1_q <= '0;
      s2_q <= '0;
    end
    else if (clk_en_i)
    begin
      s1_q <= raw_w;
      s2_q <= s1_q;
    end
  end
  logic hv_w, boost_w, rel_w, rlo_w, rhi_w, stp_w, loss_w, bo_w, pol_w, val_w, sl_w;
  assign {hv_w, boost_w, rel_w, rlo_w, rhi_w, stp_w, loss_w, bo_w, pol_w, val_w, sl_w} =
         s2_q[NS-1:3];

  // supply sequencer
  tpd_pkg::tpd_sup_t st_q;
  tpd_pkg::tpd_sup_t st_d;
  logic [23:0] tmr_q;
  logic [23:0] tmr_d;
  logic [23:0] chg_q;
  logic [23:0] chg_d;
  logic released_q;
  logic released_d;
  always_comb
  begin
    st_d = st_q;
    tmr_d = tmr_q + 24'h000001;
    chg_d = chg_q;
    released_d = released_q;
    unique case (st_q)
      tpd_pkg::TPD_SUP_IDLE:
      begin
        tmr_d = 24'h000000;
        chg_d = 24'h000000;
        if (hv_w)
          st_d = tpd_pkg::TPD_SUP_START;
      end
      tpd_pkg::TPD_SUP_START, tpd_pkg::TPD_SUP_RECHG:
      begin
        chg_d = chg_q + 24'h000001;
        if (chg_q >= 24'(CHARGE_MAX - 1))
        begin
          st_d = tpd_pkg::TPD_SUP_COOL;
          tmr_d = 24'h000000;
        end
        else if (st_q == tpd_pkg::TPD_SUP_START && rel_w)
        begin
          st_d = tpd_pkg::TPD_SUP_RUN;
          released_d = 1'b1;
        end
        else if (st_q == tpd_pkg::TPD_SUP_RECHG && rhi_w)
          st_d = tpd_pkg::TPD_SUP_RUN;
      end
      tpd_pkg::TPD_SUP_RUN:
      begin
        chg_d = 24'h000000;
        tmr_d = 24'h000000;
        if (loss_w)
          st_d = tpd_pkg::TPD_SUP_XWAIT;
        else if (!rlo_w)
          st_d = tpd_pkg::TPD_SUP_RECHG;
      end
      tpd_pkg::TPD_SUP_COOL:
      begin
        if (tmr_q >= 24'(CHARGE_RESTART - 1))
        begin
          st_d = released_q ? tpd_pkg::TPD_SUP_RECHG : tpd_pkg::TPD_SUP_START;
          chg_d = 24'h000000;
        end
      end
      tpd_pkg::TPD_SUP_XWAIT:
      begin
        if (!loss_w)
          st_d = tpd_pkg::TPD_SUP_RUN;
        else if (tmr_q >= 24'(AC_LOSS_DELAY - 1))
          st_d = tpd_pkg::TPD_SUP_XDIS;
      end
      tpd_pkg::TPD_SUP_XDIS:
      begin
        if (!stp_w)
          st_d = tpd_pkg::TPD_SUP_OFF;
        else if (!rlo_w)
          chg_d = 24'h000001;
        else if (rhi_w)
          chg_d = 24'h000000;
      end
      tpd_pkg::TPD_SUP_OFF:
        st_d = tpd_pkg::TPD_SUP_OFF;
    endcase
  end
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      st_q <= tpd_pkg::TPD_SUP_IDLE;
      tmr_q <= 24'h000000;
      chg_q <= 24'h000000;
      released_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      chg_q <= chg_d;
      released_q <= released_d;
    end
  end
  logic charging_w;
  assign charging_w = (st_q == tpd_pkg::TPD_SUP_START) || (st_q == tpd_pkg::TPD_SUP_RECHG) ||
                      (st_q == tpd_pkg::TPD_SUP_XDIS && chg_q != 24'h000000);
  assign charger_en_o = charging_w;
  assign charge_boost_o = charging_w && boost_w;
  assign xcap_drain_o = (st_q == tpd_pkg::TPD_SUP_XDIS) && (chg_q == 24'h000000);
  assign halted_o = (st_q == tpd_pkg::TPD_SUP_OFF);

  // start gating and soft-start
  logic line_ok_w;
  logic pol_rise_w;
  tpd_line_mon #(.HALF_MIN(HALF_MIN), .HALF_MAX(HALF_MAX)) u_line (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .pol_i(pol_w),
    .line_ok_o(line_ok_w),
    .pol_rise_o(pol_rise_w)
  );
  logic sw_q;
  logic sw_d;
  logic [23:0] ss_q;
  logic [23:0] ss_d;
  logic [11:0] ref_q;
  logic [11:0] ref_d;
  logic run_ok_w;
  // no switching while the supply is being drained
  assign run_ok_w = bo_w && released_q && !halted_o && !loss_w &&
                    (st_q != tpd_pkg::TPD_SUP_XDIS);
  always_comb
  begin
    sw_d = sw_q;
    ss_d = ss_q;
    ref_d = ref_q;
    if (!run_ok_w)
    begin
      sw_d = 1'b0;
      ss_d = 24'h000000;
      ref_d = 12'h000;
    end
    else if (!sw_q)
    begin
      if (line_ok_w && pol_rise_w)
        sw_d = 1'b1;
    end
    else if (ss_q < 24'(SOFT_START))
    begin
      ss_d = ss_q + 24'h000001;
      ref_d = 12'((ss_d * 36'(tpd_pkg::REF_FULL)) / 36'(SOFT_START));
    end
  end
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      sw_q <= 1'b0;
      ss_q <= 24'h000000;
      ref_q <= 12'h000;
    end
    else if (clk_en_i)
    begin
      sw_q <= sw_d;
      ss_q <= ss_d;
      ref_q <= ref_d;
    end
  end
  assign switching_o = sw_q;
  assign vref_o = ref_q;

  // undershoot gain boost with hysteresis
  logic gb_q;
  logic gb_d;
  logic [19:0] fb100_w;
  logic [19:0] lo_w;
  logic [19:0] hi_w;
  assign fb100_w = 20'(fb_i) * 20'd100;
  assign lo_w = 20'(ref_q) * 20'(tpd_pkg::BOOST_DETECT_PCT);
  assign hi_w = 20'(ref_q) * 20'(tpd_pkg::BOOST_RECOVER_PCT);
  always_comb
  begin
    gb_d = gb_q;
    if (fb100_w < lo_w)
      gb_d = 1'b1;
    else if (fb100_w >= hi_w)
      gb_d = 1'b0;
  end
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      gb_q <= 1'b0;
    else if (clk_en_i)
      gb_q <= gb_d;
  end
  assign undershoot_gain_boost_o = gb_q;

  // on-time: limited comp against sawtooth ramp, valley start, min width, dead time
  logic [11:0] lim_w;
  assign lim_w = (comp_i < limit_i) ? comp_i : limit_i;
  logic on_q;
  logic on_d;
  logic sync_q;
  logic sync_d;
  logic [11:0] ramp_q;
  logic [11:0] ramp_d;
  logic [3:0] dt_q;
  logic [3:0] dt_d;
  logic pol_q;
  logic pol_d;
  always_comb
  begin
    on_d = on_q;
    sync_d = 1'b0;
    ramp_d = ramp_q;
    dt_d = (dt_q != 4'h0) ? dt_q - 4'h1 : 4'h0;
    // polarity latched only while a main pulse runs
    pol_d = on_q ? pol_q : pol_w;
    if (!sw_q)
    begin
      on_d = 1'b0;
      ramp_d = 12'h000;
      pol_d = pol_w;
    end
    else if (on_q)
    begin
      ramp_d = ramp_q + 12'h001;
      if (ramp_q >= 12'(tpd_pkg::MIN_ON_CYC) && ramp_q >= lim_w)
      begin
        on_d = 1'b0;
        dt_d = 4'(tpd_pkg::DEAD_CYC);
      end
    end
    else if (dt_q == 4'h0 && val_w && !sync_q)
    begin
      on_d = 1'b1;
      ramp_d = 12'h000;
      pol_d = pol_w;
    end
    else if (dt_q == 4'h0 && !val_w && sl_w)
      sync_d = 1'b1;
    // leg swap: drop sync and wait out the dead time
    if (!on_q && pol_w != pol_q)
    begin
      sync_d = 1'b0;
      dt_d = 4'(tpd_pkg::DEAD_CYC);
    end
  end
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      on_q <= 1'b0;
      sync_q <= 1'b0;
      ramp_q <= 12'h000;
      dt_q <= 4'h0;
      pol_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      on_q <= on_d;
      sync_q <= sync_d && !on_d;
      ramp_q <= ramp_d;
      dt_q <= dt_d;
      pol_q <= pol_d;
    end
  end
  // outputs registered through leg mapping
  logic fl_q, fh_q, sll_q, slh_q;
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      fl_q <= 1'b0;
      fh_q <= 1'b0;
      sll_q <= 1'b0;
      slh_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      fl_q <= pol_q ? on_q : sync_q;
      fh_q <= pol_q ? sync_q : on_q;
      sll_q <= sw_q && pol_q;
      slh_q <= sw_q && !pol_q;
    end
  end
  assign fast_low_drive_o = fl_q;
  assign fast_high_drive_o = fh_q;
  assign slow_low_drive_o = sll_q;
  assign slow_high_drive_o = slh_q;

  AST_NO_SHOOT: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !(fast_low_drive_o && fast_high_drive_o))
    else $error("both fast drives high");
  AST_SLOW_POS: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    clk_en_i && sw_q && pol_q |=> slow_low_drive_o && !slow_high_drive_o)
    else $error("slow leg wrong in positive half");
  AST_SLOW_NEG: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    clk_en_i && sw_q && !pol_q |=> slow_high_drive_o && !slow_low_drive_o)
    else $error("slow leg wrong in negative half");
  AST_MAIN_POS: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    clk_en_i && on_q && pol_q |=> fast_low_drive_o)
    else $error("main pulse missing on low drive");
  AST_MIN_ON: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    $fell(on_q) |-> !$past(sw_q) || $past(ramp_q) >= 12'(tpd_pkg::MIN_ON_CYC))
    else $error("on pulse below minimum");
  AST_OFF_STOP: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    halted_o |-> !charger_en_o && !switching_o)
    else $error("activity after stop");
  AST_SYNC_LOAD: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    clk_en_i && sync_q |-> $past(sl_w))
    else $error("sync pulse without load");
  AST_START_GATE: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    clk_en_i && $rose(sw_q) |-> $past(line_ok_w) && $past(pol_rise_w))
    else $error("switching started without qualification");
  AST_CHG_MAX: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    chg_q <= 24'(CHARGE_MAX))
    else $error("charge time exceeded");
  AST_BOOST_SET: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    clk_en_i && fb100_w < lo_w |=> undershoot_gain_boost_o)
    else $error("gain boost not engaged");
endmodule

//--- tb/tpd_gate_model.sv
// gate driver model of both legs, counts forbidden overlaps
`timescale 1ns/1ps
module tpd_gate_model (
  input wire logic mclk_i,
  input wire logic fast_low_drive_i,
  input wire logic fast_high_drive_i,
  input wire logic slow_low_drive_i,
  input wire logic slow_high_drive_i,
  output logic [7:0] fast_both_o,
  output logic [7:0] slow_both_o
);
  initial fast_both_o = 8'h00;
  initial slow_both_o = 8'h00;
  always @(posedge mclk_i)
  begin
    // shoot-through on the fast leg
    if (fast_low_drive_i === 1'b1 && fast_high_drive_i === 1'b1)
      fast_both_o <= fast_both_o + 8'h01;
    // both slow switches on shorts the line
    if (slow_low_drive_i === 1'b1 && slow_high_drive_i === 1'b1)
      slow_both_o <= slow_both_o + 8'h01;
  end
endmodule

//--- tb/testbench.sv
// self-checking bench of the drive sequencer
`timescale 1ns/1ps
module testbench;
  localparam int CM = 50;
  localparam int CR = 80;
  localparam int AD = 40;
  localparam int SS = 100;
  localparam int CHG = 2;
  localparam int DRN = 4;
  localparam int SW = 5;
  localparam int UGB = 6;
  localparam int HLT = 7;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic hv = 1'b0, bst = 1'b0, rel = 1'b0, rlo = 1'b0, rhi = 1'b0, stp = 1'b0;
  logic acl = 1'b0, bok = 1'b0, pol = 1'b0, vly = 1'b0, syl = 1'b0, pol_run = 1'b0;
  logic [11:0] comp = 12'h000, lim = 12'hFFF, fb = 12'hFFF;
  logic fl, fh, sl, sh, cen, cbo, xd, sw, ugb, hlt;
  logic [11:0] vref;
  logic [7:0] mon, fboth, sboth;
  int err_count = 0;
  int checked = 0;
  int cyc = 0;
  int pcnt = 0;
  int n, wa, wb, wc, oth;
  tpd_top #(.CHARGE_MAX(CM), .CHARGE_RESTART(CR), .AC_LOSS_DELAY(AD), .SOFT_START(SS),
    .HALF_MIN(20), .HALF_MAX(40)) u_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .clk_en_i(1'b1), .hv_start_i(hv), .above_boost_i(bst), .above_release_i(rel),
    .above_rechg_low_i(rlo), .above_rechg_high_i(rhi), .above_stop_i(stp), .ac_loss_i(acl),
    .brownout_ok_i(bok), .polarity_i(pol), .valley_i(vly), .sync_load_i(syl), .comp_i(comp),
    .limit_i(lim), .fb_i(fb), .fast_low_drive_o(fl), .fast_high_drive_o(fh),
    .slow_low_drive_o(sl), .slow_high_drive_o(sh), .charger_en_o(cen), .charge_boost_o(cbo),
    .xcap_drain_o(xd), .switching_o(sw), .vref_o(vref), .undershoot_gain_boost_o(ugb),
    .halted_o(hlt));
  tpd_gate_model u_gate (.mclk_i(mclk_i), .fast_low_drive_i(fl), .fast_high_drive_i(fh),
    .slow_low_drive_i(sl), .slow_high_drive_i(sh), .fast_both_o(fboth), .slow_both_o(sboth));
  assign mon = {hlt, ugb, sw, xd, cbo, cen, fh, fl};
  initial forever #50 mclk_i = ~mclk_i;
  always @(posedge mclk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      err_count++;
      tally_and_finish();
    end
  end
  // line polarity, half period of 30 cycles
  always @(negedge mclk_i)
  begin
    if (pol_run) pcnt <= (pcnt == 29) ? 0 : pcnt + 1;
    if (pol_run && pcnt == 29) pol <= ~pol;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic wait_bit(input int k, input logic v, input int lm, output int c);
    c = 0;
    while (mon[k] !== v && c < lm)
    begin
      @(negedge mclk_i);
      c++;
    end
  endtask
  task automatic t_charge();
    hv = 1'b1;
    wait_bit(CHG, 1'b1, 10, n);
    chk("charger on", n < 10, 1);
    wait_bit(CHG, 1'b0, CM + 10, n);
    chk("charge time", n >= CM - 4 && n <= CM + 4, 1);
    wait_bit(CHG, 1'b1, CR + 10, n);
    chk("restart time", n >= CR - 4 && n <= CR + 4, 1);
    bst = 1'b1;
    wait_bit(3, 1'b1, 6, n);
    chk("boost current", mon[3], 1);
    rel = 1'b1; rlo = 1'b1; rhi = 1'b1; stp = 1'b1;
    wait_bit(CHG, 1'b0, 6, n);
    chk("charge stop", mon[CHG], 0);
    rhi = 1'b0;
    rlo = 1'b0;
    wait_bit(CHG, 1'b1, 6, n);
    chk("recharge on", mon[CHG], 1);
    rlo = 1'b1;
    repeat (6) @(negedge mclk_i);
    chk("recharge held", mon[CHG], 1);
    rhi = 1'b1;
    wait_bit(CHG, 1'b0, 6, n);
    chk("recharge off", mon[CHG], 0);
    $display("test charge done");
  endtask
  task automatic t_start();
    bok = 1'b1;
    pol_run = 1'b1;
    repeat (60) @(negedge mclk_i);
    chk("early switching", mon[SW], 0);
    wait_bit(SW, 1'b1, 200, n);
    chk("switching", mon[SW], 1);
    chk("ref low", vref < 12'h400, 1);
    repeat (SS + 10) @(negedge mclk_i);
    chk("ref full", vref, tpd_pkg::REF_FULL);
    $display("test start done");
  endtask
  task automatic pulse(input logic p, input logic [11:0] c, input logic [11:0] l, output int w);
    // leave room for the polarity synchroniser and leg registers
    while (pol !== p || pcnt != 4) @(negedge mclk_i);
    comp = c;
    lim = l;
    chk("no valley no pulse", mon[!p], 0);
    chk("slow low", sl, p);
    chk("slow high", sh, !p);
    vly = 1'b1;
    @(negedge mclk_i);
    vly = 1'b0;
    w = 0;
    oth = 0;
    repeat (22)
    begin
      @(negedge mclk_i);
      w += mon[!p];
      oth += mon[p];
    end
  endtask
  task automatic t_legs();
    pulse(1'b1, 12'h008, 12'hFFF, wa);
    chk("sync off", oth, 0);
    pulse(1'b0, 12'h008, 12'hFFF, wb);
    chk("neg width", wb, wa);
    pulse(1'b1, 12'h002, 12'hFFF, wb);
    chk("comp order", wa > wb, 1);
    pulse(1'b1, 12'h008, 12'h002, wc);
    chk("limiter", wc, wb);
    pulse(1'b1, 12'h000, 12'h000, wc);
    chk("min on", wc >= 1, 1);
    syl = 1'b1;
    pulse(1'b1, 12'h004, 12'hFFF, wc);
    chk("sync on", oth > 0, 1);
    syl = 1'b0;
    chk("fast overlap", fboth, 0);
    chk("slow overlap", sboth, 0);
    $display("test legs done");
  endtask
  task automatic t_boost();
    fb = 12'hF3C;
    repeat (6) @(negedge mclk_i);
    chk("boost idle", mon[UGB], 0);
    fb = 12'hF28;
    wait_bit(UGB, 1'b1, 6, n);
    chk("boost on", mon[UGB], 1);
    fb = 12'hF6E;
    repeat (6) @(negedge mclk_i);
    chk("boost held", mon[UGB], 1);
    fb = 12'hFD2;
    wait_bit(UGB, 1'b0, 6, n);
    chk("boost off", mon[UGB], 0);
    $display("test boost done");
  endtask
  task automatic t_discharge();
    acl = 1'b1;
    repeat (AD - 8) @(negedge mclk_i);
    chk("early drain", mon[DRN], 0);
    wait_bit(DRN, 1'b1, 20, n);
    chk("drain", mon[DRN], 1);
    rhi = 1'b0;
    rlo = 1'b0;
    wait_bit(CHG, 1'b1, 6, n);
    chk("dis recharge", mon[DRN +: 1] == 0 && mon[CHG], 1);
    rlo = 1'b1;
    rhi = 1'b1;
    wait_bit(CHG, 1'b0, 6, n);
    chk("dis drain", mon[DRN], 1);
    stp = 1'b0;
    wait_bit(HLT, 1'b1, 6, n);
    chk("halted", mon[HLT], 1);
    repeat (3) @(negedge mclk_i);
    chk("all off", {fl, fh, sl, sh, cen}, 0);
    $display("test discharge done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(negedge mclk_i);
    sys_rst_i = 1'b0;
    repeat (3) @(negedge mclk_i);
    chk("reset outputs", {mon, sl, sh, vref}, 0);
    t_charge();
    t_start();
    t_legs();
    t_boost();
    t_discharge();
    tally_and_finish();
  end
endmodule
